/* File: dv/hbsp_pci_peer.sv */
/*
 hbsp_pci_peer: the five pci masters on the board side of the bridge.
 assumes the bench says which masters want the bus and the clock run line has a pull-up.
*/
`timescale 1ns/1ns
module hbsp_pci_peer (
	input wire logic mclk,
	input wire logic [4:0] want,
	output logic [4:0] req_n,
	output logic clkrun_pull
);
	initial req_n = 5'h1F;
	// one request line per master, active low
	always @(posedge mclk) begin
		req_n <= #1 ~want;
	end
	// pull clock run low while a master needs the bus
	assign clkrun_pull = (|want) | ~(&req_n);
endmodule

/* File: dv/host_bridge_strap_pci_setup_bench.sv */
/*
 host_bridge_strap_pci_setup_bench: directed tests of straps, gating, banks, arbiter, clock run and idsel.
 assumes the design's defaults of six banks and five masters on a 25 MHz mclk.
*/
`timescale 1ns/1ns
module host_bridge_strap_pci_setup_bench;
	import hbsp_pkg::*;
	logic mclk = 1'b0;
	logic arst_n = 1'b0;
	logic [13:0] straps = 14'h1C40;
	logic gen = 1'b0, cpu = 1'b0, pci = 1'b0, sref = 1'b0, stop_req = 1'b0, cfg_start = 1'b0;
	logic [5:0] pop = 6'h00, edo = 6'h00;
	logic [4:0] dev = 5'h00, want = 5'h00;
	logic [4:0] req_n, gnt_n;
	logic straps_valid, host_freq_66, quick, gport, compat, mob, clk_gate_stop, tech_edo, mixed_err;
	logic [3:0] ioq_depth;
	logic [5:0] sdram_cke;
	logic clkrun_out, clkrun_oe, clkrun_line, peer_pull, pci_clk_run, self_hit, reject;
	logic [31:0] idsel;
	logic [9:0] strap_v;
	int error_cnt = 0;
	int n_checks = 0;

	always #20 mclk = ~mclk;
	// open-drain clock run line with pull-up
	assign clkrun_line = (peer_pull || (clkrun_oe && !clkrun_out)) ? 1'b0 : 1'b1;
	assign strap_v = {straps_valid, host_freq_66, ioq_depth, quick, gport, compat, mob};

	hbsp_pci_peer peer_u (.mclk(mclk), .want(want), .req_n(req_n), .clkrun_pull(peer_pull));

	hbsp_top dut_u (.mclk(mclk), .arst_n(arst_n), .mem_addr_strap(straps), .straps_valid(straps_valid),
		.host_freq_66(host_freq_66), .ioq_depth(ioq_depth), .quick_start_mode(quick),
		.graphics_port_disabled(gport), .module_compat_mode(compat), .mobile_buffer_mode(mob),
		.gclk_enable(gen), .cpu_active(cpu), .pci_active(pci), .clk_gate_stop(clk_gate_stop),
		.bank_populated(pop), .bank_is_edo(edo), .self_refresh(sref), .sdram_cke(sdram_cke),
		.dram_tech_edo(tech_edo), .dram_mixed_err(mixed_err), .clkrun_n_in(clkrun_line),
		.clkrun_n_out(clkrun_out), .clkrun_n_oe(clkrun_oe), .pci_stop_req(stop_req),
		.pci_clk_run(pci_clk_run), .pci_req_n(req_n), .pci_gnt_n(gnt_n), .cfg_start(cfg_start),
		.cfg_dev(dev), .cfg_idsel(idsel), .cfg_self_hit(self_hit), .cfg_reject(reject));

	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// reset with given strap pins, then wait for capture
	task automatic do_reset(input logic [13:0] pins);
		arst_n = 1'b0;
		straps = pins;
		tick(4);
		arst_n = 1'b1;
		repeat (10) if (straps_valid !== 1'b1) tick(1);
	endtask

	task automatic wait_gnt(input logic [4:0] exp);
		repeat (12) if (gnt_n !== exp) tick(1);
		chk(32'(gnt_n), 32'(exp));
	endtask

	initial begin
		do_reset(14'h1C40);
		chk(32'(strap_v), 32'h38F);
		straps = 14'h0280;
		tick(3);
		chk(32'(strap_v), 32'h38F);
		// idle gating
		gen = 1'b1;
		tick(1);
		chk(32'(clk_gate_stop), 32'h1);
		cpu = 1'b1;
		tick(1);
		chk(32'(clk_gate_stop), 32'h0);
		cpu = 1'b0;
		pci = 1'b1;
		tick(1);
		chk(32'(clk_gate_stop), 32'h0);
		pci = 1'b0;
		gen = 1'b0;
		tick(1);
		chk(32'(clk_gate_stop), 32'h0);
		// memory banks
		pop = 6'h3F;
		tick(1);
		chk(32'(sdram_cke), 32'h3F);
		sref = 1'b1;
		tick(1);
		chk(32'(sdram_cke), 32'h00);
		sref = 1'b0;
		edo = 6'h01;
		tick(1);
		chk(32'({mixed_err, sdram_cke}), 32'h40);
		edo = 6'h3F;
		tick(1);
		chk(32'({tech_edo, mixed_err}), 32'h2);
		pop = 6'h0F;
		edo = 6'h30;
		tick(1);
		chk(32'({mixed_err, tech_edo, sdram_cke}), 32'h0F);
		// configuration idsel for every device number up to 21
		for (int d = 0; d < 22; d++) begin
			dev = 5'(d);
			cfg_start = 1'b1;
			tick(1);
			cfg_start = 1'b0;
			tick(1);
			chk(idsel, (d < 2 || d > 20) ? 32'h0 : (32'h1 << (11 + d)));
			chk(32'({self_hit, reject}), (d == 0) ? 32'h2 : ((d == 1 || d > 20) ? 32'h1 : 32'h0));
		end
		// each master alone, then a handover
		for (int i = 0; i < 5; i++) begin
			want = 5'h01 << i;
			wait_gnt(~(5'h01 << i));
			want = 5'h00;
			wait_gnt(5'h1F);
		end
		want = 5'h05;
		wait_gnt(5'h1E);
		want = 5'h04;
		wait_gnt(5'h1B);
		want = 5'h00;
		wait_gnt(5'h1F);
		// clock run stop and restart by a master
		stop_req = 1'b1;
		tick(1);
		chk(32'(clkrun_oe), 32'h0);
		repeat (12) if (pci_clk_run !== 1'b0) tick(1);
		chk(32'({pci_clk_run, gnt_n}), 32'h1F);
		stop_req = 1'b0;
		want = 5'h08;
		wait_gnt(5'h17);
		chk(32'(pci_clk_run), 32'h1);
		chk(32'({clkrun_oe, clkrun_out}), 32'h2);
		want = 5'h00;
		pop = 6'h3F;
		edo = 6'h00;
		// second reset with every strap reversed
		do_reset(14'h0280);
		chk(32'(strap_v), 32'h210);
		tick(2);
		chk(32'(sdram_cke), 32'h00);
		print_verdict();
	end

	initial begin
		#(40 * 3000);
		error_cnt++;
		print_verdict();
	end
endmodule

/* File: rtl/hbsp_arb_if.sv */
/*
 hbsp_arb_if: request and grant path between the bridge top and its pci arbiter.
 assumes both ends run on mclk.
*/
`timescale 1ns/1ns
interface hbsp_arb_if #(parameter int N = 5);
	logic [N-1:0] req_n;
	logic [N-1:0] gnt_n;
	logic enable;
	logic any_req;
	modport arb (input req_n, input enable, output gnt_n, output any_req);
	modport ctl (output req_n, output enable, input gnt_n, input any_req);
endinterface

/* File: rtl/hbsp_pci_arb.sv */
/*
 hbsp_pci_arb: round robin arbiter for the external pci masters.
 assumes request pins are asynchronous and a grant may only be given while the pci clock runs.
*/
`timescale 1ns/1ns
module hbsp_pci_arb
	import hbsp_pkg::*;
#(
	parameter int N = MASTERS_MAX
) (
	input wire logic mclk,
	input wire logic arst_n,
	hbsp_arb_if.arb bus
);
	typedef struct packed {
		logic [N-1:0] s1;
		logic [N-1:0] s2;
		logic [N-1:0] gnt_n;
		logic [2:0] last;
	} hbsp_arb_st_t;

	hbsp_arb_st_t st;
	hbsp_arb_st_t next_st;
	logic [N-1:0] req;

	assign req = ~st.s2;
	assign bus.gnt_n = st.gnt_n;
	assign bus.any_req = |req;

	always_comb begin
		int idx;
		logic found;
		idx = 0;
		found = 1'b0;
		next_st = st;
		next_st.s1 = bus.req_n;
		next_st.s2 = st.s1;
		if (!bus.enable) begin
			next_st.gnt_n = '1;
		end else if (!(st.gnt_n != '1 && req[st.last])) begin
			// holder released: hand over to next requester
			next_st.gnt_n = '1;
			for (int i = 1; i <= N; i++) begin
				idx = (int'(st.last) + i) % N;
				if (!found && req[idx]) begin
					found = 1'b1;
					next_st.gnt_n[idx] = 1'b0;
					next_st.last = 3'(idx);
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{s1: '1, s2: '1, gnt_n: '1, last: 3'h0};
		end else begin
			st <= next_st;
		end
	end

	chk_gnt_onehot: assert property (@(posedge mclk) disable iff (!arst_n) $onehot0(~bus.gnt_n))
		else $error("more than one pci grant active");
	chk_gnt_disabled: assert property (@(posedge mclk) disable iff (!arst_n) !bus.enable |=> bus.gnt_n == '1)
		else $error("grant given while pci clock stopped");
endmodule

/* File: rtl/hbsp_pkg.sv */
/*
 hbsp_pkg: shared constants and types for the host bridge strap, memory and pci setup block.
 assumes a single 25 MHz clock domain and straps on the memory address bus.
*/
package hbsp_pkg;
	localparam int BANKS_MAX = 6;
	localparam int MASTERS_MAX = 5;
	localparam int MA_WIDTH = 14;
	// strap positions on the memory address bus
	localparam int POS_HOST_FREQ = 12;
	localparam int POS_QUEUE_DEPTH = 11;
	localparam int POS_QUICK_START = 10;
	localparam int POS_GPORT_DIS = 9;
	localparam int POS_MOD_CONFIG = 7;
	localparam int POS_BUF_MODE = 6;
	localparam logic [3:0] IOQ_DEPTH_MAX = 4'h8;
	localparam logic [3:0] IOQ_DEPTH_MIN = 4'h1;
	localparam logic [1:0] STRAP_SETTLE = 2'h2;
	localparam logic [2:0] CLKRUN_BLIND = 3'h3;
	localparam logic [2:0] CLKRUN_IDLE = 3'h6;
	localparam logic [31:0] IDSEL_AD11 = 32'h0000_0800;
	localparam logic [4:0] DEV_SELF = 5'h00;
	localparam logic [4:0] DEV_GPORT = 5'h01;
	localparam logic [4:0] DEV_LAST = 5'h14;
	typedef enum logic [1:0] {HBSP_CR_RUN, HBSP_CR_RELEASE, HBSP_CR_STOPPED} hbsp_cr_state_t;
endpackage

/* File: rtl/hbsp_top.sv */
/*
 hbsp_top: host bridge strap capture, clock gating, memory bank enables, clock run control,
 pci arbitration and configuration idsel generation.
 assumes straps are steady on the memory address pins around reset and all other
 control inputs except clkrun_n_in and pci_req_n come from logic on mclk.
*/
`timescale 1ns/1ns
module hbsp_top
	import hbsp_pkg::*;
#(
	parameter int NUM_BANKS = BANKS_MAX,
	parameter int NUM_MASTERS = MASTERS_MAX
) (
	input wire logic mclk,
	input wire logic arst_n,
	input wire logic [MA_WIDTH-1:0] mem_addr_strap,
	output logic straps_valid,
	output logic host_freq_66,
	output logic [3:0] ioq_depth,
	output logic quick_start_mode,
	output logic graphics_port_disabled,
	output logic module_compat_mode,
	output logic mobile_buffer_mode,
	input wire logic gclk_enable,
	input wire logic cpu_active,
	input wire logic pci_active,
	output logic clk_gate_stop,
	input wire logic [NUM_BANKS-1:0] bank_populated,
	input wire logic [NUM_BANKS-1:0] bank_is_edo,
	input wire logic self_refresh,
	output logic [NUM_BANKS-1:0] sdram_cke,
	output logic dram_tech_edo,
	output logic dram_mixed_err,
	input wire logic clkrun_n_in,
	output logic clkrun_n_out,
	output logic clkrun_n_oe,
	input wire logic pci_stop_req,
	output logic pci_clk_run,
	input wire logic [NUM_MASTERS-1:0] pci_req_n,
	output logic [NUM_MASTERS-1:0] pci_gnt_n,
	input wire logic cfg_start,
	input wire logic [4:0] cfg_dev,
	output logic [31:0] cfg_idsel,
	output logic cfg_self_hit,
	output logic cfg_reject
);
	typedef struct packed {
		logic [MA_WIDTH-1:0] strap_s1;
		logic [MA_WIDTH-1:0] strap_s2;
		logic [1:0] settle;
		logic valid;
		logic freq_66;
		logic depth_max;
		logic quick;
		logic gport_dis;
		logic compat;
		logic mob_buf;
		logic gate_stop;
		logic [NUM_BANKS-1:0] cke;
		logic tech_edo;
		logic mixed;
		logic cr_s1;
		logic cr_s2;
		hbsp_cr_state_t cr_state;
		logic [2:0] cr_cnt;
		logic cr_drive;
		logic clk_run;
		logic [31:0] idsel;
		logic self_hit;
		logic reject;
	} hbsp_st_t;

	hbsp_st_t st;
	hbsp_st_t next_st;
	logic mixed_now;
	logic any_edo;

	hbsp_arb_if #(.N(NUM_MASTERS)) arb_bus ();

	assign arb_bus.req_n = pci_req_n;
	assign arb_bus.enable = st.clk_run;
	assign pci_gnt_n = arb_bus.gnt_n;

	hbsp_pci_arb #(.N(NUM_MASTERS)) u_arb (
		.mclk(mclk),
		.arst_n(arst_n),
		.bus(arb_bus)
	);

	assign any_edo = |(bank_populated & bank_is_edo);
	assign mixed_now = any_edo && |(bank_populated & ~bank_is_edo);

	always_comb begin
		next_st = st;
		// straps
		next_st.strap_s1 = mem_addr_strap;
		next_st.strap_s2 = st.strap_s1;
		if (!st.valid) begin
			if (st.settle == STRAP_SETTLE) begin
				next_st.valid = 1'b1;
				next_st.freq_66 = st.strap_s2[POS_HOST_FREQ];
				next_st.depth_max = st.strap_s2[POS_QUEUE_DEPTH];
				next_st.quick = st.strap_s2[POS_QUICK_START];
				next_st.gport_dis = ~st.strap_s2[POS_GPORT_DIS];
				next_st.compat = ~st.strap_s2[POS_MOD_CONFIG];
				next_st.mob_buf = st.strap_s2[POS_BUF_MODE];
			end else begin
				next_st.settle = st.settle + 2'h1;
			end
		end
		// idle clock gating
		next_st.gate_stop = gclk_enable && !cpu_active && !pci_active && !arb_bus.any_req;
		// memory banks
		next_st.mixed = mixed_now;
		next_st.tech_edo = any_edo;
		for (int i = 0; i < NUM_BANKS; i++) begin
			next_st.cke[i] = bank_populated[i] && !self_refresh && !mixed_now && st.valid && st.freq_66;
		end
		// pci clock run
		next_st.cr_s1 = clkrun_n_in;
		next_st.cr_s2 = st.cr_s1;
		case (st.cr_state)
			HBSP_CR_RUN: begin
				if (pci_stop_req && !arb_bus.any_req) begin
					next_st.cr_state = HBSP_CR_RELEASE;
					next_st.cr_drive = 1'b0;
					next_st.cr_cnt = 3'h0;
				end
			end
			HBSP_CR_RELEASE: begin
				if (st.cr_cnt >= CLKRUN_BLIND && (!st.cr_s2 || arb_bus.any_req)) begin
					next_st.cr_state = HBSP_CR_RUN;
					next_st.cr_drive = 1'b1;
				end else if (st.cr_cnt == CLKRUN_IDLE) begin
					next_st.cr_state = HBSP_CR_STOPPED;
					next_st.clk_run = 1'b0;
				end else begin
					next_st.cr_cnt = st.cr_cnt + 3'h1;
				end
			end
			HBSP_CR_STOPPED: begin
				if (!st.cr_s2 || arb_bus.any_req) begin
					next_st.cr_state = HBSP_CR_RUN;
					next_st.cr_drive = 1'b1;
					next_st.clk_run = 1'b1;
				end
			end
			default: begin
				next_st.cr_state = HBSP_CR_RUN;
				next_st.cr_drive = 1'b1;
				next_st.clk_run = 1'b1;
			end
		endcase
		// configuration idsel
		if (cfg_start) begin
			next_st.idsel = 32'h0000_0000;
			next_st.self_hit = 1'b0;
			next_st.reject = 1'b0;
			if (cfg_dev == DEV_SELF) begin
				next_st.self_hit = 1'b1;
			end else if (cfg_dev == DEV_GPORT || cfg_dev > DEV_LAST) begin
				next_st.reject = 1'b1;
			end else begin
				next_st.idsel = IDSEL_AD11 << cfg_dev;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			st <= '{strap_s1: '1, strap_s2: '1, settle: 2'h0, valid: 1'b0,
				freq_66: 1'b1, depth_max: 1'b1, quick: 1'b1, gport_dis: 1'b1, compat: 1'b1, mob_buf: 1'b1,
				gate_stop: 1'b0, cke: '0, tech_edo: 1'b0, mixed: 1'b0, cr_s1: 1'b1, cr_s2: 1'b1,
				cr_state: HBSP_CR_RUN, cr_cnt: 3'h0, cr_drive: 1'b1, clk_run: 1'b1,
				idsel: 32'h0000_0000, self_hit: 1'b0, reject: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	assign straps_valid = st.valid;
	assign host_freq_66 = st.freq_66;
	assign ioq_depth = st.depth_max ? IOQ_DEPTH_MAX : IOQ_DEPTH_MIN;
	assign quick_start_mode = st.quick;
	assign graphics_port_disabled = st.gport_dis;
	assign module_compat_mode = st.compat;
	assign mobile_buffer_mode = st.mob_buf;
	assign clk_gate_stop = st.gate_stop;
	assign sdram_cke = st.cke;
	assign dram_tech_edo = st.tech_edo;
	assign dram_mixed_err = st.mixed;
	assign clkrun_n_out = 1'b0;
	assign clkrun_n_oe = st.cr_drive;
	assign pci_clk_run = st.clk_run;
	assign cfg_idsel = st.idsel;
	assign cfg_self_hit = st.self_hit;
	assign cfg_reject = st.reject;

	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);

	chk_gate_idle: assert property (gclk_enable && !cpu_active && !pci_active
		&& $past(pci_req_n, 2) == '1 |=> clk_gate_stop)
		else $error("clock not gated while idle");
	chk_cke_refresh: assert property (self_refresh |=> sdram_cke == '0)
		else $error("clock enable high during self refresh");
	chk_cke_freq: assert property (!host_freq_66 |=> sdram_cke == '0)
		else $error("banks enabled at unsupported speed");
	chk_mixed_tech: assert property (dram_mixed_err |-> sdram_cke == '0)
		else $error("mixed row technology operated");
	chk_strap_hold: assert property (straps_valid |=> straps_valid && $stable(host_freq_66)
		&& $stable(ioq_depth) && $stable(quick_start_mode))
		else $error("strap setting changed after capture");
	chk_freq_strap: assert property ($rose(straps_valid) |-> host_freq_66 == $past(st.strap_s2[POS_HOST_FREQ]))
		else $error("host frequency strap misread");
	chk_depth_strap: assert property ($rose(straps_valid) && $past(st.strap_s2[POS_QUEUE_DEPTH])
		|-> ioq_depth == IOQ_DEPTH_MAX)
		else $error("queue depth not maximum when unstrapped");
	chk_quick_strap: assert property ($rose(straps_valid) |-> quick_start_mode == $past(st.strap_s2[POS_QUICK_START]))
		else $error("quick start strap misread");
	chk_gport_strap: assert property ($rose(straps_valid) |-> graphics_port_disabled
		== !$past(st.strap_s2[POS_GPORT_DIS]))
		else $error("graphics port strap misread");
	chk_clkrun_wake: assert property (!pci_clk_run && !st.cr_s2 |=> pci_clk_run && clkrun_n_oe)
		else $error("clock run request ignored");
	chk_no_ad11: assert property (cfg_start && cfg_dev == DEV_SELF |=> cfg_self_hit && cfg_idsel == 32'h0000_0000)
		else $error("line 11 raised for the bridge");
	chk_idsel_line: assert property (cfg_start && cfg_dev > DEV_GPORT && cfg_dev <= DEV_LAST
		|=> cfg_idsel == (IDSEL_AD11 << $past(cfg_dev)) && !cfg_reject)
		else $error("wrong idsel line");
endmodule
